// ==== ee_eeprom.sv ====
// How it works
// - Data line only pulled low, else released
// - Sample on clock rise, change after fall
// - Write protect high blocks all array writes
// - 128 pages of 16 bytes, 11-bit address
// - Data changes only while clock is low
// - Data falling with clock high is start
// - Data rising with clock high is stop
// - Eight-bit words, acknowledged on ninth clock
// - Standby at power-up and after stop, once any write cycle ends
// - Device word: 1010, block bits, read/write
// - Low bit one reads, zero writes
// - Match acknowledges; mismatch returns to standby
// - Byte write then stop starts timed cycle
// - Inputs ignored during internal write cycle
// - Page write takes up to sixteen bytes
// - Write increments low nibble, wraps in page
// - Polling acknowledged only after write completes
// - Counter holds last address plus one
// - Current read sends byte at counter
// - Master acknowledge continues read, wraps array
`timescale 1ns/100ps
`default_nettype none
module ee_fifo #(
    parameter int unsigned WIDTH = 12,
    parameter int unsigned DEPTH = 8
) (
    // Clock
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    logic [WIDTH-1:0] buf_r [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;

    assign in_ready = cnt_r != FULL;
    assign out_valid = cnt_r != '0;
    assign out_data = buf_r[rp_r];
    assign push = clk_en & in_valid & in_ready;
    assign pop = clk_en & out_valid & out_ready;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            buf_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= wp_r + AW'(1);
            end
            if (pop) begin
                rp_r <= rp_r + AW'(1);
            end
            if (push && !pop) begin
                cnt_r <= cnt_r + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_r <= cnt_r - (AW+1)'(1);
            end
        end
    end
endmodule : ee_fifo

module ee_eeprom #(
    parameter int unsigned WR_CYCLES = ee_pkg::WR_CYC
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Two-wire bus pins
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Write protect
    input wire logic wp_i,
    // Status
    output logic standby
);
    import ee_pkg::*;

    // ************************************
    // Pin synchronisers and bus events
    // ************************************
    ee_bus_t pin_s1_r;
    ee_bus_t pin_s2_r;
    ee_bus_t pin_d_r;
    logic wp_s1_r;
    logic wp_s2_r;
    logic scl_rise;
    logic scl_fall;
    logic start_w;
    logic stop_w;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pin_s1_r <= '1;
            pin_s2_r <= '1;
            pin_d_r <= '1;
            wp_s1_r <= 1'b1;
            wp_s2_r <= 1'b1;
        end else if (clk_en) begin
            pin_s1_r <= '{scl: scl_i, sda: sda_i};
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
            wp_s1_r <= wp_i;
            wp_s2_r <= wp_s1_r;
        end
    end

    assign scl_rise = clk_en & pin_s2_r.scl & ~pin_d_r.scl;
    assign scl_fall = clk_en & ~pin_s2_r.scl & pin_d_r.scl;
    // Edges of data with clock high
    assign start_w = clk_en & pin_s2_r.scl & pin_d_r.scl & pin_d_r.sda & ~pin_s2_r.sda;
    assign stop_w = clk_en & pin_s2_r.scl & pin_d_r.scl & ~pin_d_r.sda & pin_s2_r.sda;

    // ************************************
    // Protocol state
    // ************************************
    ee_state_t state_r;
    ee_state_t ack_next_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] sh_r;
    logic [7:0] tx_r;
    logic [2:0] blk_r;
    logic [10:0] addr_r;
    logic [6:0] page_r;
    logic rw_r;
    logic mack_r;
    logic drv_r;
    logic busy_r;
    logic wr_pend_r;
    logic stop_pend_r;
    logic standby_r;
    logic proto_ok;
    logic byte_done;
    logic rd_end;
    logic [7:0] mem_q;
    logic [7:0] mem_r [MEM_BYTES];
    ee_wr_word_t fifo_in;
    ee_wr_word_t fifo_out;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;

    // Busy masks every pin event
    assign proto_ok = clk_en & ~busy_r & ~start_w & ~stop_w;
    assign byte_done = scl_fall && bit_cnt_r == LAST_BIT;
    assign rd_end = proto_ok && state_r == ST_RD && byte_done;
    assign mem_q = mem_r[addr_r];
    assign sda_o = 1'b0;
    assign sda_oe = drv_r;
    assign standby = standby_r;

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            ack_next_r <= ST_IDLE;
            bit_cnt_r <= '0;
            sh_r <= '0;
            tx_r <= '0;
            blk_r <= '0;
            rw_r <= 1'b0;
            mack_r <= 1'b0;
            drv_r <= 1'b0;
        end else if (clk_en) begin
            if (busy_r) begin
                state_r <= ST_IDLE;
                drv_r <= 1'b0;
            end else if (start_w) begin
                // Any start outside a write cycle resyncs, also after a recovery run
                state_r <= ST_DEV;
                bit_cnt_r <= '0;
                drv_r <= 1'b0;
            end else if (stop_w) begin
                state_r <= ST_IDLE;
                drv_r <= 1'b0;
            end else begin
                if (scl_rise && bit_cnt_r != LAST_BIT) begin
                    sh_r <= {sh_r[6:0], pin_s2_r.sda};
                    bit_cnt_r <= bit_cnt_r + 4'h1;
                end
                unique case (state_r)
                    ST_IDLE: begin
                    end
                    ST_DEV: begin
                        if (byte_done) begin
                            if (sh_r[7:4] == DEV_ID) begin
                                drv_r <= 1'b1;
                                rw_r <= sh_r[0];
                                blk_r <= sh_r[3:1];
                                state_r <= ST_ACK;
                                ack_next_r <= sh_r[0] ? ST_RD : ST_WORD;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_WORD: begin
                        if (byte_done) begin
                            drv_r <= 1'b1;
                            state_r <= ST_ACK;
                            ack_next_r <= ST_WDATA;
                        end
                    end
                    ST_WDATA: begin
                        if (byte_done) begin
                            // Full buffer refuses the byte rather than lose it
                            if (fifo_in_ready) begin
                                drv_r <= 1'b1;
                                state_r <= ST_ACK;
                                ack_next_r <= ST_WDATA;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            bit_cnt_r <= '0;
                            state_r <= ack_next_r;
                            if (ack_next_r == ST_RD) begin
                                drv_r <= ~mem_q[7];
                                tx_r <= {mem_q[6:0], 1'b0};
                            end else begin
                                drv_r <= 1'b0;
                            end
                        end
                    end
                    ST_RD: begin
                        if (scl_fall) begin
                            if (bit_cnt_r == LAST_BIT) begin
                                drv_r <= 1'b0;
                                bit_cnt_r <= '0;
                                state_r <= ST_MACK;
                            end else begin
                                drv_r <= ~tx_r[7];
                                tx_r <= {tx_r[6:0], 1'b0};
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            mack_r <= ~pin_s2_r.sda;
                        end
                        if (scl_fall) begin
                            bit_cnt_r <= '0;
                            if (mack_r) begin
                                state_r <= ST_RD;
                                drv_r <= ~mem_q[7];
                                tx_r <= {mem_q[6:0], 1'b0};
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ************************************
    // Address counter
    // ************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            addr_r <= ADDR_RST;
        end else if (proto_ok && state_r == ST_WORD && byte_done) begin
            addr_r <= {blk_r, sh_r};
        end else if (fifo_in_valid && fifo_in_ready) begin
            addr_r <= {addr_r[10:4], addr_r[3:0] + 4'h1};
        end else if (rd_end) begin
            addr_r <= addr_r + 11'h001;
        end
    end

    // ************************************
    // Write buffer and page latch
    // ************************************
    assign fifo_in_valid = proto_ok && state_r == ST_WDATA && byte_done;
    assign fifo_in = '{col: addr_r[3:0], data: sh_r};

    ee_fifo #(
        .WIDTH($bits(ee_wr_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_ee_fifo (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(~busy_r),
        .out_data(fifo_out)
    );

    logic [7:0] latch_r [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_r;
    logic [31:0] wr_cnt_r;
    logic commit_go;
    logic commit_end;
    logic drain;

    // Commit waits for the buffer to empty so no byte is left behind
    assign commit_go = clk_en & stop_pend_r & ~busy_r & ~fifo_out_valid;
    assign commit_end = clk_en & busy_r & (wr_cnt_r == WR_CYCLES - 1);
    assign drain = clk_en & fifo_out_valid & ~busy_r;

    always_ff @(posedge ref_clk) begin
        if (drain) begin
            latch_r[fifo_out.col] <= fifo_out.data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            mask_r <= '0;
        end else if (drain) begin
            mask_r[fifo_out.col] <= 1'b1;
        end else if (commit_end || (commit_go && wp_s2_r)) begin
            mask_r <= '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_pend_r <= 1'b0;
            stop_pend_r <= 1'b0;
            page_r <= '0;
        end else if (clk_en) begin
            if (fifo_in_valid && fifo_in_ready) begin
                wr_pend_r <= 1'b1;
                page_r <= addr_r[10:4];
            end else if (commit_go) begin
                wr_pend_r <= 1'b0;
            end
            if (stop_w && !busy_r && wr_pend_r) begin
                stop_pend_r <= 1'b1;
            end else if (commit_go) begin
                stop_pend_r <= 1'b0;
            end
        end
    end

    // ************************************
    // Internal write cycle
    // ************************************
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            busy_r <= 1'b0;
            wr_cnt_r <= '0;
        end else if (commit_go && !wp_s2_r) begin
            busy_r <= 1'b1;
            wr_cnt_r <= '0;
        end else if (commit_end) begin
            busy_r <= 1'b0;
        end else if (clk_en && busy_r) begin
            wr_cnt_r <= wr_cnt_r + 32'h1;
        end
    end

    // One latched byte per cycle, early in the cycle
    always_ff @(posedge ref_clk) begin
        if (clk_en && busy_r && wr_cnt_r < PAGE_BYTES && mask_r[wr_cnt_r[3:0]]) begin
            mem_r[{page_r, wr_cnt_r[3:0]}] <= latch_r[wr_cnt_r[3:0]];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            standby_r <= STBY_RST;
        end else if (clk_en) begin
            standby_r <= state_r == ST_IDLE && !busy_r && !stop_pend_r && !commit_go;
        end
    end

    // ************************************
    // Checks
    // ************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Pull only in an ack or read bit slot, released everywhere else
    property p_od_only;
        sda_oe |-> sda_o == 1'b0 && (state_r == ST_ACK || state_r == ST_RD);
    endproperty
    a_od_only: assert property (p_od_only) else $error("data pin driven high");

    property p_drive_on_fall;
        $rose(sda_oe) |-> $past(scl_fall);
    endproperty
    a_drive_on_fall: assert property (p_drive_on_fall) else $error("drive began off a falling clock");

    property p_wp_block;
        commit_go && wp_s2_r |=> !busy_r && mask_r == '0;
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protected write went ahead");

    property p_busy_quiet;
        busy_r |=> !sda_oe && state_r == ST_IDLE;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("response during write cycle");

    property p_busy_starts;
        commit_go && !wp_s2_r |=> busy_r [*8];
    endproperty
    a_busy_starts: assert property (p_busy_starts) else $error("write cycle did not start");

    property p_dev_ack;
        proto_ok && state_r == ST_DEV && byte_done && sh_r[7:4] == DEV_ID
            |=> sda_oe && state_r == ST_ACK && rw_r == $past(sh_r[0]);
    endproperty
    a_dev_ack: assert property (p_dev_ack) else $error("matched address not acknowledged");

    property p_dev_nack;
        proto_ok && state_r == ST_DEV && byte_done && sh_r[7:4] != DEV_ID
            |=> !sda_oe && state_r == ST_IDLE;
    endproperty
    a_dev_nack: assert property (p_dev_nack) else $error("mismatch acknowledged");

    property p_page_fixed;
        fifo_in_valid && fifo_in_ready
            |=> addr_r[10:4] == $past(addr_r[10:4]) && addr_r[3:0] == $past(addr_r[3:0]) + 4'h1;
    endproperty
    a_page_fixed: assert property (p_page_fixed) else $error("write left its page");

    property p_word_addr;
        proto_ok && state_r == ST_WORD && byte_done |=> addr_r == {blk_r, $past(sh_r)};
    endproperty
    a_word_addr: assert property (p_word_addr) else $error("word address wrong");

    property p_read_wrap;
        rd_end && addr_r == 11'h7ff |=> addr_r == 11'h000;
    endproperty
    a_read_wrap: assert property (p_read_wrap) else $error("read did not wrap");

    property p_ack_release;
        proto_ok && state_r == ST_ACK && scl_fall && ack_next_r != ST_RD |=> !sda_oe;
    endproperty
    a_ack_release: assert property (p_ack_release) else $error("ack held past ninth clock");

    c_write_cycle: cover property (commit_go && !wp_s2_r ##1 busy_r);
    c_read_byte: cover property (rd_end);
    c_seq_read: cover property (state_r == ST_MACK && scl_fall && mack_r);
    c_nack_dev: cover property (proto_ok && state_r == ST_DEV && byte_done && sh_r[7:4] != DEV_ID);
endmodule : ee_eeprom
`default_nettype wire

// ==== ee_pkg.sv ====
`default_nettype none
package ee_pkg;
    // ************************************
    // Bus and array geometry
    // ************************************
    localparam logic [3:0] DEV_ID = 4'ha;
    localparam logic [3:0] LAST_BIT = 4'h8;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned MEM_BYTES = 2048;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam logic [10:0] ADDR_RST = 11'h000;
    localparam logic STBY_RST = 1'b1;
    // ************************************
    // Timing
    // ************************************
    localparam int unsigned CLK_MHZ = 50;
    // internal_write_cycle_time, microseconds
    localparam int unsigned WR_TIME_US = 3000;
    // Longest time, times the clock in MHz gives the exact cycle count
    localparam int unsigned WR_CYC = WR_TIME_US * CLK_MHZ;
    // ************************************
    // Types
    // ************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_DEV, ST_WORD, ST_WDATA, ST_ACK, ST_RD, ST_MACK
    } ee_state_t;
    typedef struct packed {
        logic scl;
        logic sda;
    } ee_bus_t;
    typedef struct packed {
        logic [3:0] col;
        logic [7:0] data;
    } ee_wr_word_t;
endpackage : ee_pkg
`default_nettype wire

// ==== ee_master_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module ee_master_model (
    // Clock
    input wire logic ref_clk,
    // Bus wires
    output var logic scl,
    output var logic sda_m,
    input wire logic sda_w
);
    // Slow quarter bit so the pin synchronisers always see each phase
    localparam int QTR = 5;
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic qw();
        repeat (QTR) @(posedge ref_clk);
        #1;
    endtask : qw
    task automatic start();
        sda_m = 1'b1;
        qw();
        scl = 1'b1;
        qw();
        sda_m = 1'b0;
        qw();
        scl = 1'b0;
        qw();
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        qw();
        scl = 1'b1;
        qw();
        sda_m = 1'b1;
        qw();
    endtask : stop
    task automatic xfer(input logic b, output logic r);
        sda_m = b;
        qw();
        scl = 1'b1;
        qw();
        r = sda_w;
        qw();
        scl = 1'b0;
        qw();
    endtask : xfer
    task automatic byte_w(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(d[i], r);
        end
        xfer(1'b1, r);
        ack = ~r;
    endtask : byte_w
    task automatic byte_r(input logic give_ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, d[i]);
        end
        xfer(~give_ack, r);
    endtask : byte_r
    task automatic recover();
        logic r;
        repeat (9) xfer(1'b1, r);
        start();
        stop();
    endtask : recover
endmodule : ee_master_model
`default_nettype wire

// ==== tb_ee_eeprom.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_ee_eeprom;
    import ee_pkg::*;
    // Short write cycle keeps the run brief
    localparam int unsigned WR_SIM = 400;
    logic ref_clk;
    logic reset_n;
    logic clk_en;
    logic wp_i;
    logic scl;
    logic sda_m;
    wire logic sda_w;
    logic sda_o;
    logic sda_oe;
    logic standby;
    logic [7:0] mem_exp [MEM_BYTES];
    int err_total;
    int compares;
    // Pull-up wire shared by both parties
    assign sda_w = sda_m & (sda_oe ? sda_o : 1'b1);
    ee_eeprom #(.WR_CYCLES(WR_SIM)) u_ee_eeprom (
        .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .standby(standby)
    );
    ee_master_model u_ee_master_model (.ref_clk(ref_clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done
    task automatic set_addr(input logic [10:0] a);
        logic ack;
        u_ee_master_model.start();
        u_ee_master_model.byte_w({DEV_ID, a[10:8], 1'b0}, ack);
        chk("dev ack", 8'(ack), 8'h01);
        u_ee_master_model.byte_w(a[7:0], ack);
        chk("word ack", 8'(ack), 8'h01);
    endtask : set_addr
    task automatic wr_seq(input logic [10:0] a, input int n, input logic [7:0] base);
        logic ack;
        logic [3:0] col;
        set_addr(a);
        for (int k = 0; k < n; k++) begin
            col = a[3:0] + 4'(k);
            u_ee_master_model.byte_w(base + 8'(k), ack);
            chk("data ack", 8'(ack), 8'h01);
            if (wp_i == 1'b0) begin
                mem_exp[{a[10:4], col}] = base + 8'(k);
            end
        end
        u_ee_master_model.stop();
    endtask : wr_seq
    task automatic wait_write();
        logic ack;
        ack = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        chk("busy standby", 8'(standby), 8'h00);
        for (int t = 0; t < 10 && !ack; t++) begin
            u_ee_master_model.start();
            u_ee_master_model.byte_w({DEV_ID, 3'h0, 1'b0}, ack);
            if (t == 0) begin
                chk("poll busy", 8'(ack), 8'h00);
            end
            u_ee_master_model.stop();
        end
        chk("poll done", 8'(ack), 8'h01);
    endtask : wait_write
    task automatic rd_body(input logic [10:0] a, input int n);
        logic ack;
        logic [7:0] d;
        u_ee_master_model.start();
        u_ee_master_model.byte_w({DEV_ID, a[10:8], 1'b1}, ack);
        chk("read ack", 8'(ack), 8'h01);
        for (int k = 0; k < n; k++) begin
            u_ee_master_model.byte_r(k != n - 1, d);
            chk("read data", d, mem_exp[11'(a + 11'(k))]);
        end
        u_ee_master_model.stop();
        repeat (10) @(posedge ref_clk);
        #1;
        chk("idle standby", 8'(standby), 8'h01);
    endtask : rd_body
    task automatic rd_check(input logic [10:0] a, input int n);
        set_addr(a);
        rd_body(a, n);
    endtask : rd_check
    task automatic t_reset();
        chk("reset standby", 8'(standby), 8'(STBY_RST));
        chk("reset drive", 8'(sda_oe), 8'h00);
        u_ee_master_model.recover();
    endtask : t_reset
    task automatic t_mismatch();
        logic ack;
        u_ee_master_model.start();
        u_ee_master_model.byte_w(8'h50, ack);
        chk("foreign ack", 8'(ack), 8'h00);
        u_ee_master_model.stop();
    endtask : t_mismatch
    task automatic t_freeze();
        logic ack;
        // Enable low: a whole matching frame must pass unseen
        clk_en = 1'b0;
        u_ee_master_model.start();
        u_ee_master_model.byte_w({DEV_ID, 3'h3, 1'b1}, ack);
        chk("frozen ack", 8'(ack), 8'h00);
        chk("frozen standby", 8'(standby), 8'h01);
        u_ee_master_model.stop();
        clk_en = 1'b1;
    endtask : t_freeze
    task automatic t_page();
        // Eighteen bytes from column e: the last two overwrite the first two
        wr_seq(11'h30e, 18, 8'h40);
        wait_write();
        rd_check(11'h300, 16);
    endtask : t_page
    task automatic t_current();
        rd_check(11'h300, 4);
        rd_body(11'h304, 2);
    endtask : t_current
    task automatic t_wrap();
        wr_seq(11'h7ff, 1, 8'ha5);
        wait_write();
        wr_seq(11'h000, 1, 8'h5a);
        wait_write();
        rd_check(11'h7ff, 2);
    endtask : t_wrap
    task automatic t_protect();
        wp_i = 1'b1;
        wr_seq(11'h302, 1, 8'hee);
        repeat (60) @(posedge ref_clk);
        #1;
        chk("wp standby", 8'(standby), 8'h01);
        rd_check(11'h302, 1);
        wp_i = 1'b0;
    endtask : t_protect
    initial begin
        err_total = 0;
        compares = 0;
        reset_n = 1'b0;
        clk_en = 1'b1;
        wp_i = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1;
        t_reset();
        t_mismatch();
        t_freeze();
        t_page();
        t_current();
        t_wrap();
        t_protect();
        test_done();
    end
    // Whole run needs roughly 15000 cycles
    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        test_done();
    end
endmodule : tb_ee_eeprom
`default_nettype wire
